// File: hw/dual_six_bit_pwm.sv
// Two six-bit pulse width modulator channels with an APB register slave.
// Assumes the bus clock is clock_i; stop mode is modelled by stop_i freezing the channels and holding pready low.
`include "pwm_defs.svh"
module dual_six_bit_pwm
  import pwm_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic arst_n_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Low-power stop request.
  input wire logic stop_i,
  // Modulator outputs and pin ownership, index 0 is channel a.
  output logic [1:0] pwm_o,
  output logic [1:0] pin_select_o
);
  logic access;
  logic [1:0] hit_ctrl;
  logic [1:0] hit_duty;
  logic [7:0] control_reg [2];
  logic [5:0] duty_reg [2];
  logic [5:0] buffer_reg [2];
  logic [1:0] pending_reg;
  logic [1:0] wrap;
  logic [31:0] rdata_next;
  logic map_hit;

  // A write lands only at the edge where pready is seen high, even if stop rises at that edge.
  assign access = psel_i && penable_i && pready_o;
  assign hit_ctrl[0] = paddr_i == `CHAN_A_CONTROL_ADDR;
  assign hit_ctrl[1] = paddr_i == `CHAN_B_CONTROL_ADDR;
  assign hit_duty[0] = paddr_i == `CHAN_A_DUTY_ADDR;
  assign hit_duty[1] = paddr_i == `CHAN_B_DUTY_ADDR;
  assign map_hit = |{hit_ctrl, hit_duty};

  // Stop holds pready low; an access phase held over a stop is answered once stop falls.
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
    end
    else
    begin
      pready_o <= psel_i && !stop_i && (!penable_i || !pready_o);
      pslverr_o <= psel_i && !stop_i && (!penable_i || !pready_o) && !map_hit;
      prdata_o <= rdata_next;
    end
  end

  always_comb
  begin
    rdata_next = 32'h0;
    if (hit_ctrl[0])
      rdata_next = {24'h0, control_reg[0]};
    if (hit_ctrl[1])
      rdata_next = {24'h0, control_reg[1]};
    if (hit_duty[0])
      rdata_next = {26'h0, duty_reg[0]};
    if (hit_duty[1])
      rdata_next = {26'h0, duty_reg[1]};
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_chan
      logic [1:0] coarse;
      logic [3:0] fine;
      logic enabled;
      logic [3:0] first_cnt_reg;
      logic [3:0] fine_cnt_reg;
      logic [5:0] count_reg;
      logic first_tick;
      logic second_tick;
      logic active;

      assign coarse = control_reg[ch][`COARSE_DIV_MSB:`COARSE_DIV_LSB];
      assign fine = control_reg[ch][`FINE_DIV_MSB:`FINE_DIV_LSB];
      assign enabled = coarse != coarse_off;
      assign wrap[ch] = second_tick && count_reg == `COUNT_LAST;

      // Control writes land at once; the prescaler compares against them from the next clock edge.
      always_ff @(posedge clock_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          control_reg[ch] <= `CONTROL_RESET;
        else if (access && pwrite_i && hit_ctrl[ch])
          control_reg[ch] <= {1'b0, pwdata_i[6:0]};
      end

      // First stage runs at bus rate divided by 1, 8 or 16.
      always_comb
      begin
        case (coarse)
          coarse_div1: first_tick = 1'b1;
          coarse_div8: first_tick = first_cnt_reg == `COARSE_DIV8;
          coarse_div16: first_tick = first_cnt_reg == `COARSE_DIV16;
          default: first_tick = 1'b0;
        endcase
      end
      assign second_tick = first_tick && fine_cnt_reg == fine;

      always_ff @(posedge clock_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          first_cnt_reg <= 4'h0;
          fine_cnt_reg <= 4'h0;
          count_reg <= 6'h00;
        end
        else if (!enabled)
        begin
          first_cnt_reg <= 4'h0;
          fine_cnt_reg <= 4'h0;
          count_reg <= 6'h00;
        end
        else if (!stop_i)
        begin
          first_cnt_reg <= first_tick ? 4'h0 : first_cnt_reg + 4'h1;
          if (first_tick)
            fine_cnt_reg <= second_tick ? 4'h0 : fine_cnt_reg + 4'h1;
          if (second_tick)
            count_reg <= count_reg + 6'h01;
        end
      end

      // Duty has no reset so its contents survive it.
      always_ff @(posedge clock_i)
      begin
        if (access && pwrite_i && hit_duty[ch])
        begin
          buffer_reg[ch] <= pwdata_i[`DUTY_MSB:0];
          if (!enabled)
            duty_reg[ch] <= pwdata_i[`DUTY_MSB:0];
        end
        else if (pending_reg[ch] && wrap[ch] && !stop_i)
          duty_reg[ch] <= buffer_reg[ch];
      end

      always_ff @(posedge clock_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          pending_reg[ch] <= 1'b0;
        else if (access && pwrite_i && hit_duty[ch])
          pending_reg[ch] <= enabled;
        else if (wrap[ch] && !stop_i)
          pending_reg[ch] <= 1'b0;
      end

      assign active = count_reg < duty_reg[ch];

      always_ff @(posedge clock_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          pwm_o[ch] <= 1'b0;
          pin_select_o[ch] <= 1'b0;
        end
        else if (!stop_i)
        begin
          pin_select_o[ch] <= enabled;
          pwm_o[ch] <= enabled && (active == control_reg[ch][`POLARITY_BIT]);
        end
      end
    end
  endgenerate
endmodule : dual_six_bit_pwm

// File: hw/pwm_defs.svh
// Register offsets, field positions and reset values of the dual six-bit modulator.
// Assumes an APB slave with 32-bit data; each register takes one aligned word.
// What this block does
// - Two independent channels, each with a six-bit counter of 64 states.
// - Both channels run from the bus clock, half the oscillator rate.
// - Coarse field: 00 off, 01 divide 1, 10 divide 8, 11 divide 16.
// - Fine field divides the first-stage clock by its value plus one.
// - Output period is the second-stage clock divided by 64.
// - Polarity 0 with duty zero gives a constant high output.
// - Polarity 1 makes the pulse active high, 0 active low.
// - While enabled, written duty waits in a buffer until period end.
// - While disabled, written duty goes to the active register at once.
// - Control writes take effect immediately, even while enabled.
// - Duty reads return the active value, never the buffered one.
// - Nonzero coarse field gives the pin to the modulator; 00 returns it.
// - Coarse field 00 stops prescaler and counter to save power.
// - Channel b behaves exactly like channel a on its own pin.
// - Duty values keep their contents through reset.
// - Reset clears the coarse fields, disabling channels and driving outputs low.
// - Channels keep running in wait mode.
// - In stop mode each channel freezes wherever its waveform stood.
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH
`define CHAN_A_CONTROL_ADDR 12'h000
`define CHAN_B_CONTROL_ADDR 12'h004
`define CHAN_A_DUTY_ADDR 12'h008
`define CHAN_B_DUTY_ADDR 12'h00c
`define FINE_DIV_LSB 0
`define FINE_DIV_MSB 3
`define COARSE_DIV_LSB 4
`define COARSE_DIV_MSB 5
`define POLARITY_BIT 6
`define DUTY_MSB 5
`define CONTROL_RESET 8'h00
`define COARSE_DIV8 4'h7
`define COARSE_DIV16 4'hf
`define COUNT_LAST 6'h3f
`endif

// File: hw/pwm_pkg.sv
// Types shared by the dual six-bit modulator.
// Assumes the constants header is included alongside.
package pwm_pkg;
  typedef enum logic [1:0] {
    coarse_off = 2'h0,
    coarse_div1 = 2'h1,
    coarse_div8 = 2'h2,
    coarse_div16 = 2'h3
  } coarse_e;
endpackage : pwm_pkg

// File: testbench/pwm_monitor.sv
// Checker on the ports of the dual six-bit modulator.
// Assumes it is bound to the design from the bench top file.
module pwm_monitor (
  input logic clock_i,
  input logic arst_n_i,
  input logic psel_i,
  input logic penable_i,
  input logic pwrite_i,
  input logic [11:0] paddr_i,
  input logic [31:0] pwdata_i,
  input logic [31:0] prdata_o,
  input logic pready_o,
  input logic pslverr_o,
  input logic stop_i,
  input logic [1:0] pwm_o,
  input logic [1:0] pin_select_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_setup; psel_i && !penable_i && !stop_i; endsequence
  a_ready_follows: assert property (s_setup ##1 !stop_i |-> pready_o) else $error("late");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("long");
  a_bad_addr: assert property (pready_o && paddr_i > 12'h00c |-> pslverr_o) else $error("map");
  a_good_addr: assert property (pready_o && paddr_i < 12'h00d |-> !pslverr_o) else $error("err");
  a_off_low: assert property ((pwm_o & ~pin_select_o) == 2'h0) else $error("idle");
  a_stop_hold: assert property (stop_i && $past(stop_i) |-> $stable(pwm_o)) else $error("stop");
  a_stop_bus: assert property ($past(stop_i) |-> !pready_o) else $error("bus");
  a_pin_owner: assert property (pready_o && pwrite_i && paddr_i == 12'h000 |-> ##2
    pin_select_o[0] == ($past(pwdata_i[5:4], 2) != 2'h0)) else $error("pin");
endmodule : pwm_monitor

// File: testbench/tb.sv
// Bench driving the modulator's APB port and stop pin.
// Assumes the design and pwm_monitor are compiled before it.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, arst_n_i, psel_i, penable_i, pwrite_i, stop_i, pready_o, pslverr_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [1:0] pwm_o, pin_select_o, held;
  int num_errors, compares;
  dual_six_bit_pwm dut_u (.*);
  initial
    forever #10 clock_i = ~clock_i;
  task stop_test;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t %h %h", $time, got, exp);
    end
  endtask : chk
  task xfer(input logic w, logic [11:0] a, logic [31:0] d);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, w, a, d};
    @(posedge clock_i);
    penable_i <= 1'h1;
    do @(posedge clock_i); while (pready_o !== 1'h1);
    rd = prdata_o;
    {psel_i, penable_i} <= 2'h0;
    @(posedge clock_i);
  endtask : xfer
  // Counting over one whole period makes the phase irrelevant.
  task automatic highs(input int ch, n, exp);
    int c = 0;
    repeat (4) @(posedge clock_i);
    repeat (n)
    begin
      @(posedge clock_i);
      c += pwm_o[ch];
    end
    chk(c, exp);
  endtask : highs
  task t_chan_a;
    xfer(1'h1, 12'h008, 32'h5);
    xfer(1'h1, 12'h000, 32'h50);
    highs(0, 64, 5);
    xfer(1'h1, 12'h008, 32'h3f);
    xfer(1'h0, 12'h008, 32'h0);
    chk(rd, 32'h5);
    repeat (64) @(posedge clock_i);
    highs(0, 64, 63);
  endtask : t_chan_a
  task t_chan_b;
    xfer(1'h1, 12'h00c, 32'h21);
    xfer(1'h1, 12'h004, 32'h21);
    highs(1, 1024, 496);
    chk(pin_select_o, 32'h3);
    stop_i <= 1'h1;
    repeat (2) @(posedge clock_i);
    held = pwm_o;
    repeat (28) @(posedge clock_i);
    chk(pwm_o, held);
    stop_i <= 1'h0;
    xfer(1'h0, 12'h010, 32'h0);
    chk(rd, 32'h0);
  endtask : t_chan_b
  initial
  begin
    {clock_i, arst_n_i, psel_i, penable_i, pwrite_i, stop_i, paddr_i, pwdata_i} = '0;
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'h1;
    t_chan_a();
    t_chan_b();
    stop_test();
  end
  initial
  begin
    repeat (9000) @(posedge clock_i);
    num_errors++;
    stop_test();
  end
endmodule : tb
bind dual_six_bit_pwm pwm_monitor mon_u (.*);
